//--- src/lfs_consts.vh
`ifndef LFS_CONSTS_VH
`define LFS_CONSTS_VH

// Fault status bit positions
`define LFS_LINK_LOSS_BIT      15
`define LFS_FRAME_ERR_BIT      14
`define LFS_CUR_HIGH_BIT       13
`define LFS_CUR_LOW_BIT        12
`define LFS_OVERTEMP_BIT       11
`define LFS_WARMTEMP_BIT       10
`define LFS_SUP_CRIT_BIT       9
`define LFS_SUP_WARN_BIT       8
`define LFS_FAULT_RESET        16'h0000

// Control field positions (serial control word)
`define LFS_CTRL_WDOG_DIS_BIT  12
`define LFS_CTRL_READBACK_BIT  11
`define LFS_CTRL_NO_ALARM_BIT  10
`define LFS_CTRL_CRIT_ALERT_BIT 9
`define LFS_CTRL_MEAS_SEL_BIT  8
`define LFS_CTRL_RESET         16'h0000

// Command codes (upper byte of 24-bit frame)
`define LFS_CMD_WR_CTRL        8'h04
`define LFS_CMD_RD_FAULT       8'h85

// Thresholds in measurement codes (voltage: code*2.5/256, temp: 312-1.559*code)
`define LFS_T140_CODE          8'h6e
`define LFS_T125_CODE          8'h78
`define LFS_T100_CODE          8'h88
`define LFS_T85_CODE           8'h92
`define LFS_V03_CODE           8'h1f
`define LFS_V04_CODE           8'h29
`define LFS_V06_CODE           8'h3d
`define LFS_V07_CODE           8'h48

// Watchdog timeout in microseconds and cycles at 40 MHz
`define LFS_CLK_MHZ            40
`define LFS_WDOG_US            1000
`define LFS_WDOG_CYC           (`LFS_WDOG_US * `LFS_CLK_MHZ)

`endif

//--- src/lfs_fault_status.v
`timescale 1ns/100ps
`include "lfs_consts.vh"

// Operation
// - Set link-loss bit on watchdog timeout
// - Link loss forces alarm unless disabled
// - Alarm direction follows sampled polarity pin
// - Set frame-error bit on a frame of nonzero length that is not 24 bits long
// - Current-high bit while loop over programmed
// - Current-low bit while loop under programmed
// - Overtemp sets above 140, clears below 125
// - Warm flag sets above 100, clears below 85
// - Critical supply sets under 0.3, clears 0.4
// - Warning supply sets under 0.6, clears 0.7
// - Alert uses all flags except warning ones
// - Low byte is selected measurement code
// - Voltage code scales 2.5/256 volts
// - Temperature code is 312 minus 1.559 each
// - Fault register ignores host writes
// - Readback shifts fault word during writes
// - Control bit gates critical supply alert
module lfs_fault_status (
  input  wire       core_clk,
  input  wire       reset,
  input  wire       sync_n,
  input  wire       sclk,
  input  wire       sdin,
  input  wire       alarm_dir_pin,
  input  wire       cur_over,
  input  wire       cur_under,
  input  wire [7:0] volt_code,
  input  wire [7:0] temp_code,
  input  wire       meas_valid,
  output reg        sdo_q,
  output reg        sdo_oe_q,
  output reg        fault_q,
  output reg        alarm_force_q,
  output reg        alarm_upscale_q,
  output reg [15:0] ctrl_q
);
  // Pin synchronisers
  reg  [1:0]  sclk_s_q;
  reg  [1:0]  sync_s_q;
  reg  [1:0]  sdin_s_q;
  reg  [1:0]  dir_s_q;
  reg  [1:0]  ovr_s_q;
  reg  [1:0]  und_s_q;
  reg         sclk_d_q;
  reg  [23:0] shin_q;
  reg  [4:0]  bitcnt_q;
  reg  [15:0] shout_q;
  reg         frame_q;
  reg  [31:0] wdog_q;
  reg         link_loss_q;
  reg         frame_err_q;
  reg         cur_high_q;
  reg         cur_low_q;
  reg  [7:0]  meas_q;
  wire        overtemp;
  wire        warmtemp;
  wire        sup_crit;
  wire        sup_warn;
  wire [15:0] fault_word;
  wire        rise;
  wire        fall;
  wire        frame_end;
  wire        frame_start;

  // Two-stage synchronisers on all pins
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      sclk_s_q <= 2'h0;
      sync_s_q <= 2'h3;
      sdin_s_q <= 2'h0;
      dir_s_q  <= 2'h0;
      ovr_s_q  <= 2'h0;
      und_s_q  <= 2'h0;
      sclk_d_q <= 1'b0;
    end else begin
      sclk_s_q <= {sclk_s_q[0], sclk};
      sync_s_q <= {sync_s_q[0], sync_n};
      sdin_s_q <= {sdin_s_q[0], sdin};
      dir_s_q  <= {dir_s_q[0], alarm_dir_pin};
      ovr_s_q  <= {ovr_s_q[0], cur_over};
      und_s_q  <= {und_s_q[0], cur_under};
      sclk_d_q <= sclk_s_q[1];
    end
  end

  assign rise        = sclk_s_q[1] & ~sclk_d_q;
  assign fall        = ~sclk_s_q[1] & sclk_d_q;
  assign frame_start = ~sync_s_q[1] & ~frame_q;
  assign frame_end   = sync_s_q[1] & frame_q;

  // A frame counts as valid only with exactly 24 bits
  function frame_ok;
    input [4:0] n;
    begin
      frame_ok = (n == 5'd24);
    end
  endfunction

  // Temperature flags: higher temperature means lower code
  lfs_hyst #(.SET_CODE(`LFS_T140_CODE), .CLR_CODE(`LFS_T125_CODE), .SET_LOW(1'b1)) u_ot (
    .core_clk (core_clk),
    .reset    (reset),
    .code     (temp_code),
    .valid    (meas_valid),
    .flag_q   (overtemp)
  );
  lfs_hyst #(.SET_CODE(`LFS_T100_CODE), .CLR_CODE(`LFS_T85_CODE), .SET_LOW(1'b1)) u_wt (
    .core_clk (core_clk),
    .reset    (reset),
    .code     (temp_code),
    .valid    (meas_valid),
    .flag_q   (warmtemp)
  );
  // Supply flags: lower voltage means lower code
  lfs_hyst #(.SET_CODE(`LFS_V03_CODE), .CLR_CODE(`LFS_V04_CODE), .SET_LOW(1'b1)) u_sc (
    .core_clk (core_clk),
    .reset    (reset),
    .code     (volt_code),
    .valid    (meas_valid),
    .flag_q   (sup_crit)
  );
  lfs_hyst #(.SET_CODE(`LFS_V06_CODE), .CLR_CODE(`LFS_V07_CODE), .SET_LOW(1'b1)) u_sw (
    .core_clk (core_clk),
    .reset    (reset),
    .code     (volt_code),
    .valid    (meas_valid),
    .flag_q   (sup_warn)
  );

  // Fault word, built only from hardware state
  assign fault_word = {link_loss_q, frame_err_q, cur_high_q, cur_low_q,
                       overtemp, warmtemp, sup_crit, sup_warn, meas_q};

  // Serial frame receive, length check, control writes and readback shift
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      shin_q      <= 24'h000000;
      bitcnt_q    <= 5'h00;
      shout_q     <= `LFS_FAULT_RESET;
      frame_q     <= 1'b0;
      ctrl_q      <= `LFS_CTRL_RESET;
      frame_err_q <= 1'b0;
      sdo_q       <= 1'b0;
      sdo_oe_q    <= 1'b0;
      wdog_q      <= 32'h0;
      link_loss_q <= 1'b0;
    end else begin
      if (frame_start) begin
        frame_q  <= 1'b1;
        bitcnt_q <= 5'h00;
        shout_q  <= fault_word;
        // Readback drives only when enabled
        sdo_oe_q <= ctrl_q[`LFS_CTRL_READBACK_BIT];
        sdo_q    <= fault_word[15];
      end else if (frame_q) begin
        if (rise) begin
          shin_q   <= {shin_q[22:0], sdin_s_q[1]};
          if (bitcnt_q != 5'h1f)
            bitcnt_q <= bitcnt_q + 5'h01; // Saturate so long frames never wrap to 24
        end
        if (fall) begin
          shout_q <= {shout_q[14:0], 1'b0};
          sdo_q   <= shout_q[14];
        end
      end
      if (frame_end) begin
        frame_q  <= 1'b0;
        sdo_oe_q <= 1'b0;
        // Only full 24-bit frames write the control word
        if (frame_ok(bitcnt_q) && shin_q[23:16] == `LFS_CMD_WR_CTRL)
          ctrl_q <= shin_q[15:0];
        // Any other nonzero length is a broken frame, held until reset
        if (!frame_ok(bitcnt_q) && bitcnt_q != 5'd0)
          frame_err_q <= 1'b1;
      end
      // Watchdog restarts only on a complete frame, so line noise cannot feed it
      if (frame_end && frame_ok(bitcnt_q)) begin
        wdog_q      <= 32'h0;
        link_loss_q <= 1'b0;
      end else if (ctrl_q[`LFS_CTRL_WDOG_DIS_BIT]) begin
        wdog_q <= 32'h0;
      end else if (wdog_q >= `LFS_WDOG_CYC - 1) begin
        link_loss_q <= 1'b1;
      end else begin
        wdog_q <= wdog_q + 32'h1;
      end
    end
  end

  // Loop current compare flags and measurement code select
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cur_high_q <= 1'b0;
      cur_low_q  <= 1'b0;
      meas_q     <= 8'h00;
    end else begin
      cur_high_q <= ovr_s_q[1];
      cur_low_q  <= und_s_q[1];
      if (meas_valid)
        meas_q <= ctrl_q[`LFS_CTRL_MEAS_SEL_BIT] ? temp_code : volt_code;
    end
  end

  // Alert and alarm outputs
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      fault_q         <= 1'b0;
      alarm_force_q   <= 1'b0;
      alarm_upscale_q <= 1'b0;
    end else begin
      fault_q <= link_loss_q | frame_err_q | cur_high_q | cur_low_q | overtemp |
                 (sup_crit & ctrl_q[`LFS_CTRL_CRIT_ALERT_BIT]);
      alarm_force_q   <= link_loss_q & ~ctrl_q[`LFS_CTRL_NO_ALARM_BIT];
      alarm_upscale_q <= dir_s_q[1];
    end
  end
endmodule

//--- src/lfs_hyst.v
`timescale 1ns/100ps
`include "lfs_consts.vh"

// Hysteretic comparator on an 8-bit code: set when crossing set level
module lfs_hyst #(
  parameter [7:0] SET_CODE = 8'h00,
  parameter [7:0] CLR_CODE = 8'h00,
  parameter       SET_LOW  = 1'b0
) (
  input  wire       core_clk,
  input  wire       reset,
  input  wire [7:0] code,
  input  wire       valid,
  output reg        flag_q
);
  // Set on one side of the band, clear only past the other edge
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      flag_q <= 1'b0;
    end else if (valid) begin
      if (SET_LOW ? (code < SET_CODE) : (code > SET_CODE))
        flag_q <= 1'b1;
      else if (SET_LOW ? (code > CLR_CODE) : (code < CLR_CODE))
        flag_q <= 1'b0;
    end
  end
endmodule

//--- tb/lfs_asserts.sv
`timescale 1ns/100ps
module lfs_asserts (
  input wire        core_clk,
  input wire        reset,
  input wire        sync_n,
  input wire        alarm_dir_pin,
  input wire        cur_over,
  input wire        cur_under,
  input wire        sdo_oe_q,
  input wire        fault_q,
  input wire        alarm_force_q,
  input wire        alarm_upscale_q,
  input wire [15:0] ctrl_q
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // Quiet link, and a frame that opens with readback on or with readback off
  sequence idle_s; sync_n [*8]; endsequence
  sequence rb_start_s; $fell(sync_n) && ctrl_q[11]; endsequence
  sequence quiet_start_s; $fell(sync_n) && !ctrl_q[11]; endsequence
  // Alert and alarm relations
  a_over_alert: assert property ($rose(cur_over) |-> ##[1:8] fault_q)
    else $error("over current gave no alert");
  a_under_alert: assert property ($rose(cur_under) |-> ##[1:8] fault_q)
    else $error("under current gave no alert");
  a_held_alert: assert property (cur_over [*8] |-> fault_q)
    else $error("alert low while a cause is held");
  a_alarm_dir: assert property (alarm_force_q |-> alarm_upscale_q == $past(alarm_dir_pin, 3))
    else $error("alarm direction differs from pin");
  a_alarm_gate: assert property (ctrl_q[10] |-> !$rose(alarm_force_q))
    else $error("alarm forced while disabled");
  a_force_alert: assert property ($rose(alarm_force_q) |-> ##[0:2] fault_q)
    else $error("link loss gave no alert");
  // Serial output enable
  a_oe_idle: assert property (idle_s |-> !sdo_oe_q)
    else $error("output enabled outside a frame");
  a_oe_readback: assert property (rb_start_s |-> ##[1:8] sdo_oe_q)
    else $error("no readback drive in frame");
  a_oe_quiet: assert property (quiet_start_s |-> !sdo_oe_q [*8])
    else $error("output driven with readback off");
endmodule
bind lfs_fault_status lfs_asserts u_chk (.core_clk, .reset, .sync_n, .alarm_dir_pin,
  .cur_over, .cur_under, .sdo_oe_q, .fault_q, .alarm_force_q, .alarm_upscale_q, .ctrl_q);

//--- tb/lfs_fault_status_bench.sv
`timescale 1ns/100ps
module lfs_fault_status_bench;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic cur_over = 1'b0;
  logic cur_under = 1'b0;
  logic meas_valid = 1'b0;
  logic alarm_dir_pin = 1'b1;
  logic [7:0] volt_code = 8'h50;
  logic [7:0] temp_code = 8'ha0;
  logic sync_n, sclk, sdin, sdo_q, sdo_oe_q, fault_q, alarm_force_q, alarm_upscale_q;
  logic [15:0] ctrl_q;
  logic [23:0] rx;
  logic [9:0] tt[8] = '{10'h0a0, 10'h180, 10'h36c, 10'h370, 10'h375, 10'h17a, 10'h190, 10'h0a0};
  logic [9:0] vt[9] = '{10'h050, 10'h040, 10'h130, 10'h124, 10'h318, 10'h324, 10'h12c,
                        10'h144, 10'h04c};
  int mismatches = 0;
  int checks_done = 0;
  // Core clock
  always #12.5 core_clk = ~core_clk;
  lfs_fault_status DUT (.core_clk, .reset, .sync_n, .sclk, .sdin, .alarm_dir_pin,
    .cur_over, .cur_under, .volt_code, .temp_code, .meas_valid, .sdo_q, .sdo_oe_q,
    .fault_q, .alarm_force_q, .alarm_upscale_q, .ctrl_q);
  lfs_host host (.core_clk, .sdo_q, .sync_n, .sclk, .sdin);
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic wr(input logic [15:0] d);
    host.xfer(24, {8'h04, d}, rx);
  endtask
  // New codes, then a readback write showing flags and the code
  task automatic step(input logic tm, input logic [7:0] c, input logic [1:0] fl);
    volt_code = tm ? 8'h50 : c;
    temp_code = tm ? c : 8'ha0;
    meas_valid = 1'b1;
    cyc(1);
    meas_valid = 1'b0;
    cyc(4);
    wr(ctrl_q);
    // Fault word leads the frame, so it sits in the top 16 bits taken
    chk(rx[23:8], {4'h0, tm ? {fl, 2'b00} : {2'b00, fl}, c});
    chk(fault_q, fl[1]);
  endtask
  task automatic pulse(input logic o, input logic u);
    cur_over = o;
    cur_under = u;
    cyc(10);
    chk(fault_q, o | u);
  endtask
  task automatic t_wdog;
    int k;
    for (k = 0; k < 41000 && fault_q !== 1'b1; k++) cyc(1);
    if (k == 41000) begin
      mismatches++;
      tally_and_finish;
    end
    chk(k > 39900, 1);
    chk({alarm_force_q, alarm_upscale_q}, 2'b11);
    alarm_dir_pin = 1'b0;
    cyc(4);
    chk({alarm_force_q, alarm_upscale_q}, 2'b10);
    wr(16'h1d00);
    cyc(4);
    chk({fault_q, alarm_force_q, ctrl_q}, {2'b00, 16'h1d00});
    $display("watchdog test done");
  endtask
  task automatic t_misc;
    pulse(1, 0);
    pulse(0, 0);
    pulse(0, 1);
    pulse(0, 0);
    foreach (tt[i]) step(1, tt[i][7:0], tt[i][9:8]);
    wr(16'h1a00);
    foreach (vt[i]) step(0, vt[i][7:0], vt[i][9:8]);
    $display("flag test done");
  endtask
  task automatic t_ferr;
    host.xfer(23, {8'h04, 16'h1800}, rx);
    cyc(4);
    chk({fault_q, ctrl_q}, {1'b1, 16'h1a00});
    wr(16'h1a00);
    chk(rx[23:8], 16'h404c);
    chk(fault_q, 1'b1);
    $display("frame error test done");
  endtask
  // Main sequence
  initial begin
    cyc(8);
    reset = 1'b0;
    t_wdog;
    t_misc;
    t_ferr;
    tally_and_finish;
  end
endmodule

//--- tb/lfs_host.sv
`timescale 1ns/100ps
// Host side: MSB first, sclk idles low and stands still between frames
module lfs_host (
  input  wire  core_clk,
  input  wire  sdo_q,
  output logic sync_n,
  output logic sclk,
  output logic sdin
);
  initial begin
    sync_n = 1'b1;
    sclk = 1'b0;
    sdin = 1'b0;
  end
  // Step n core cycles, landing just past the edge
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // Send the top n bits of w, taking sdo at each sclk rise
  task automatic xfer(input int n, input logic [23:0] w, output logic [23:0] rx);
    rx = 24'h0;
    tick(1);
    sync_n = 1'b0;
    for (int i = 23; i > 23 - n; i--) begin
      sdin = w[i];
      tick(4);
      sclk = 1'b1;
      rx = {rx[22:0], sdo_q};
      tick(4);
      sclk = 1'b0;
    end
    tick(4);
    sync_n = 1'b1;
    sdin = ~sdin; // Released line shows no stale bit
    tick(8);
  endtask
endmodule
